// ### hw/eirq_flag_bank.sv
// Generic bank of sticky event flags with write-one-to-clear and an enable gate.
`timescale 1ns/1ps
`default_nettype none
module eirq_flag_bank
    import eirq_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk, // Block clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic clk_en, // Freezes the flags while low.
    input wire logic [WIDTH-1:0] event_in, // One-cycle event pulses.
    input wire logic [WIDTH-1:0] clear_in, // Write-one-to-clear bits.
    input wire logic [WIDTH-1:0] enable_in, // Matching enable bits.
    output logic [WIDTH-1:0] flag_q, // Sticky flags.
    output logic pending // Some enabled flag is set.
);

    // Elaboration-time refusal of widths the register word cannot hold.
    if (WIDTH < 1 || WIDTH > DATA_W) begin : gen_width_check
        $error("eirq_flag_bank: WIDTH out of range");
    end

    logic [WIDTH-1:0] flag_d;

    always_comb begin
        flag_d = (flag_q & ~clear_in) | event_in;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= '0;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

    assign pending = |(flag_q & enable_in);

endmodule
`default_nettype wire

// ### hw/eirq_regs.sv
// Interrupt flag and mask registers for the two event managers, with the request toward the processor.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module eirq_regs
    import eirq_pkg::*;
(
    input wire logic ref_clk, // 100 MHz block clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [ADDR_W-1:0] bus_addr, // Register word address.
    input wire logic [DATA_W-1:0] bus_wdata, // Write data.
    input wire logic bus_wr, // Write strobe.
    input wire logic bus_rd, // Read strobe.
    output logic [DATA_W-1:0] bus_rdata_q, // Read data, one cycle after the strobe.
    input wire eirq_timer_evt_type timer_two_evt, // Timer two event pulses.
    input wire eirq_trio_evt_type capture_lo_evt, // Capture one to three pulses.
    input wire eirq_timer_evt_type timer_three_evt, // Timer three event pulses.
    input wire eirq_trio_evt_type compare_hi_evt, // Compare four to six pulses.
    input wire logic drive_protection_evt, // Drive protection event pulse.
    input wire eirq_timer_evt_type timer_four_evt, // Timer four event pulses.
    input wire eirq_trio_evt_type capture_hi_evt, // Capture four to six pulses.
    output logic [3:0] timer_two_irq_enable, // Timer two enables toward the first manager.
    output logic [2:0] capture_lo_irq_enable, // Capture one to three enables.
    output logic first_event_manager_irq_gate, // Some first-manager enable is set.
    output logic second_event_manager_irq // Request from the second manager.
);

    // The first manager's flags live outside this block, so only its enables are driven out.

    logic wr_en;
    logic [3:0] timer2_en_q;
    logic [2:0] cap_lo_en_q;
    logic [15:0] t3c_en_q;
    logic [15:0] t3c_clear;
    logic [3:0] t4_clear;
    logic [2:0] cap_hi_clear;
    logic [7:0] t3c_event;
    logic [7:0] t3c_flag;
    logic [7:0] t3c_enable;
    logic [3:0] t4_flag;
    logic [2:0] cap_hi_flag;
    logic t3c_pend;
    logic t4_pend;
    logic cap_hi_pend;
    logic [DATA_W-1:0] rdata_d;

    assign wr_en = bus_wr & clk_en;

    // Compacts a 16-bit timer-three/compare word to its eight live bits.
    function automatic logic [7:0] pack_t3c(input logic [15:0] w);
        pack_t3c = {w[POS_T3_LO+3:POS_T3_LO], w[POS_CMP_LO+2:POS_CMP_LO], w[POS_PROTECT]};
    endfunction

    // Spreads eight live bits back to the register layout.
    function automatic logic [15:0] unpack_t3c(input logic [7:0] b);
        unpack_t3c = {5'h00, b[7:4], 3'h0, b[3:1], b[0]};
    endfunction

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            timer2_en_q <= RST_ZERO[3:0];
        end else if (wr_en && bus_addr == OFS_TIMER2_IRQ_ENABLE) begin
            timer2_en_q <= bus_wdata[3:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cap_lo_en_q <= RST_ZERO[2:0];
        end else if (wr_en && bus_addr == OFS_CAPTURE_LO_IRQ_ENABLE) begin
            cap_lo_en_q <= bus_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            t3c_en_q <= RST_TIMER3_COMPARE_IRQ_ENABLE;
        end else if (wr_en && bus_addr == OFS_TIMER3_COMPARE_IRQ_ENABLE) begin
            t3c_en_q <= bus_wdata & MASK_TIMER3_COMPARE;
        end
    end

    always_comb begin
        t3c_clear = '0;
        t4_clear = '0;
        cap_hi_clear = '0;
        if (bus_wr) begin
            if (bus_addr == OFS_TIMER3_COMPARE_IRQ_FLAGS) begin
                t3c_clear = bus_wdata & MASK_TIMER3_COMPARE;
            end
            if (bus_addr == OFS_TIMER4_IRQ_FLAGS) begin
                t4_clear = bus_wdata[3:0];
            end
            if (bus_addr == OFS_CAPTURE_HI_IRQ_FLAGS) begin
                cap_hi_clear = bus_wdata[2:0];
            end
        end
    end

    // Flag layout of timer three and compares.
    always_comb begin
        t3c_event = {timer_three_evt.overflow, timer_three_evt.underflow, timer_three_evt.compare,
                     timer_three_evt.period, compare_hi_evt.unit3, compare_hi_evt.unit2,
                     compare_hi_evt.unit1, drive_protection_evt};
    end

    assign t3c_enable = pack_t3c(t3c_en_q);

    eirq_flag_bank #(
        .WIDTH(8)
    ) u_t3c_flags (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .event_in(t3c_event),
        .clear_in(pack_t3c(t3c_clear)),
        .enable_in(t3c_enable),
        .flag_q(t3c_flag),
        .pending(t3c_pend)
    );

    eirq_flag_bank #(
        .WIDTH(4)
    ) u_t4_flags (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .event_in(timer_four_evt),
        .clear_in(t4_clear),
        .enable_in(4'hf),
        .flag_q(t4_flag),
        .pending(t4_pend)
    );

    eirq_flag_bank #(
        .WIDTH(3)
    ) u_cap_hi_flags (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .event_in(capture_hi_evt),
        .clear_in(cap_hi_clear),
        .enable_in(3'h7),
        .flag_q(cap_hi_flag),
        .pending(cap_hi_pend)
    );

    // Timer-four and capture-hi enables are outside this block; their flags request unconditionally here.
    // Combined request.
    assign second_event_manager_irq = t3c_pend | t4_pend | cap_hi_pend;
    assign timer_two_irq_enable = timer2_en_q;
    assign capture_lo_irq_enable = cap_lo_en_q;
    assign first_event_manager_irq_gate = |timer2_en_q | |cap_lo_en_q;

    always_comb begin
        rdata_d = '0;
        case (bus_addr)
            OFS_TIMER2_IRQ_ENABLE: rdata_d = {12'h000, timer2_en_q};
            OFS_CAPTURE_LO_IRQ_ENABLE: rdata_d = {13'h0000, cap_lo_en_q};
            OFS_TIMER3_COMPARE_IRQ_FLAGS: rdata_d = unpack_t3c(t3c_flag);
            OFS_TIMER4_IRQ_FLAGS: rdata_d = {12'h000, t4_flag};
            OFS_CAPTURE_HI_IRQ_FLAGS: rdata_d = {13'h0000, cap_hi_flag};
            OFS_TIMER3_COMPARE_IRQ_ENABLE: rdata_d = t3c_en_q;
            default: rdata_d = '0;
        endcase
    end

    // Read data stands in the cycle after the strobe and is held while clk_en is low; otherwise it reads zero.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus_rdata_q <= '0;
        end else if (clk_en) begin
            bus_rdata_q <= bus_rd ? rdata_d : '0;
        end
    end

endmodule
`default_nettype wire

// ### pkg/eirq_pkg.sv
// Register map, field layout and event carrier types for the event interrupt flag and mask registers.
package eirq_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // Byte-free word addresses of the six registers.
    localparam logic [15:0] OFS_TIMER2_IRQ_ENABLE = 16'h742d;
    localparam logic [15:0] OFS_CAPTURE_LO_IRQ_ENABLE = 16'h742e;
    localparam logic [15:0] OFS_TIMER3_COMPARE_IRQ_FLAGS = 16'h752f;
    localparam logic [15:0] OFS_TIMER4_IRQ_FLAGS = 16'h7530;
    localparam logic [15:0] OFS_CAPTURE_HI_IRQ_FLAGS = 16'h7531;
    localparam logic [15:0] OFS_TIMER3_COMPARE_IRQ_ENABLE = 16'h752c;

    // Implemented bits of each register; everything else reads zero.
    localparam logic [15:0] MASK_TIMER_QUAD = 16'h000f;
    localparam logic [15:0] MASK_CAPTURE = 16'h0007;
    localparam logic [15:0] MASK_TIMER3_COMPARE = 16'h078f;

    // Field positions inside the timer-three/compare registers.
    localparam int POS_PROTECT = 0;
    localparam int POS_CMP_LO = 1;
    localparam int POS_T3_LO = 7;

    // Field positions inside the timer quad registers.
    localparam int POS_PERIOD = 0;
    localparam int POS_COMPARE = 1;
    localparam int POS_UNDERFLOW = 2;
    localparam int POS_OVERFLOW = 3;

    // Reset values.
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_TIMER3_COMPARE_IRQ_ENABLE = 16'h0001;

    // Event pulses from one general-purpose timer.
    typedef struct packed {
        logic overflow;
        logic underflow;
        logic compare;
        logic period;
    } eirq_timer_evt_type;

    // Event pulses from three capture or compare units, unit one in bit 0.
    typedef struct packed {
        logic unit3;
        logic unit2;
        logic unit1;
    } eirq_trio_evt_type;

    // Register bus request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } eirq_bus_req_type;

endpackage

// ### tb/eirq_regs_checker.sv
// Port-level assertions for the event interrupt flag and mask registers.
`timescale 1ns/1ps
`default_nettype none
module eirq_regs_checker
    import eirq_pkg::*;
(
    input wire logic ref_clk, // Clock.
    input wire logic reset, // Reset.
    input wire logic clk_en, // Clock enable.
    input wire logic [ADDR_W-1:0] bus_addr, // Address.
    input wire logic [DATA_W-1:0] bus_wdata, // Write data.
    input wire logic bus_wr, // Write strobe.
    input wire logic bus_rd, // Read strobe.
    input wire logic [DATA_W-1:0] bus_rdata_q, // Read data.
    input wire eirq_timer_evt_type timer_three_evt, // Timer three events.
    input wire logic drive_protection_evt, // Protection event.
    input wire eirq_timer_evt_type timer_four_evt, // Timer four events.
    input wire logic [3:0] timer_two_irq_enable, // Timer two enables.
    input wire logic [2:0] capture_lo_irq_enable, // Capture enables.
    input wire logic first_event_manager_irq_gate, // Enable gate.
    input wire logic second_event_manager_irq // Request.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence rd_flags_s;
        bus_rd && clk_en && bus_addr == OFS_TIMER3_COMPARE_IRQ_FLAGS;
    endsequence
    sequence prot_rd_s;
        drive_protection_evt && clk_en ##1 rd_flags_s;
    endsequence
    sequence per_rd_s;
        timer_three_evt.period && clk_en ##1 rd_flags_s;
    endsequence
    gate_or_a: assert property (
        first_event_manager_irq_gate == (|{timer_two_irq_enable, capture_lo_irq_enable}))
        else $error("enable gate wrong");
    t2_write_a: assert property (bus_wr && clk_en && bus_addr == OFS_TIMER2_IRQ_ENABLE
        |=> timer_two_irq_enable == $past(bus_wdata[3:0])) else $error("timer two enable write lost");
    cap_write_a: assert property (bus_wr && clk_en && bus_addr == OFS_CAPTURE_LO_IRQ_ENABLE
        |=> capture_lo_irq_enable == $past(bus_wdata[2:0])) else $error("capture enable write lost");
    t2_hold_a: assert property (!(bus_wr && bus_addr == OFS_TIMER2_IRQ_ENABLE)
        |=> $stable(timer_two_irq_enable)) else $error("timer two enable moved");
    rdata_idle_a: assert property (!bus_rd && clk_en |=> bus_rdata_q == 16'h0000)
        else $error("read data not idle");
    t3_reserved_a: assert property (rd_flags_s |=> (bus_rdata_q & ~MASK_TIMER3_COMPARE) == 16'h0000)
        else $error("reserved flag bits set");
    prot_flag_a: assert property (prot_rd_s |=> bus_rdata_q[0]) else $error("protection flag missing");
    period_flag_a: assert property (per_rd_s |=> bus_rdata_q[7]) else $error("period flag missing");
    t4_irq_a: assert property (timer_four_evt.period && clk_en |=> second_event_manager_irq)
        else $error("timer four request missing");
endmodule
bind eirq_regs eirq_regs_checker eirq_regs_checker_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
    .timer_three_evt(timer_three_evt), .drive_protection_evt(drive_protection_evt),
    .timer_four_evt(timer_four_evt), .timer_two_irq_enable(timer_two_irq_enable),
    .capture_lo_irq_enable(capture_lo_irq_enable), .first_event_manager_irq_gate(first_event_manager_irq_gate),
    .second_event_manager_irq(second_event_manager_irq));
`default_nettype wire

// ### tb/tb_eirq_regs.sv
// Self-checking bench for the event interrupt flag and mask registers.
`timescale 1ns/1ps
`default_nettype none
module tb_eirq_regs
    import eirq_pkg::*;
;
    logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
    logic [15:0] bus_addr = 16'h0000, bus_wdata = 16'h0000;
    logic [21:0] evs = 22'h000000;
    logic [15:0] bus_rdata_q;
    logic [3:0] t2_en;
    logic [2:0] cap_en;
    logic gate, irq;
    int errors = 0, num_checks = 0;
    logic [15:0] ad [7] = '{16'h742d, 16'h742e, 16'h752f, 16'h7530, 16'h7531, 16'h752c, 16'h7500};
    logic [15:0] wm [7] = '{16'h000f, 16'h0007, 16'h0000, 16'h0000, 16'h0000, 16'h078f, 16'h0000};
    always #5 ref_clk = ~ref_clk;
    eirq_regs eirq_regs_i (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
        .timer_two_evt(evs[21:18]), .capture_lo_evt(evs[17:15]), .timer_three_evt(evs[14:11]),
        .compare_hi_evt(evs[10:8]), .drive_protection_evt(evs[7]), .timer_four_evt(evs[6:3]),
        .capture_hi_evt(evs[2:0]), .timer_two_irq_enable(t2_en), .capture_lo_irq_enable(cap_en),
        .first_event_manager_irq_gate(gate), .second_event_manager_irq(irq));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Each task starts just after a rising edge and ends just after one.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus_wr <= 1'b1; bus_addr <= a; bus_wdata <= d;
        @(posedge ref_clk) bus_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        bus_rd <= 1'b1; bus_addr <= a;
        @(posedge ref_clk) bus_rd <= 1'b0;
        #1 chk(bus_rdata_q, e);
        @(posedge ref_clk);
    endtask
    // No trailing edge, so a read may follow the event directly.
    task automatic pulse(input logic [21:0] v);
        evs <= v;
        @(posedge ref_clk) evs <= 22'h000000;
    endtask
    task automatic irq_is(input logic e);
        #1 chk({15'h0000, irq}, {15'h0000, e});
    endtask
    initial begin
        #60000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 7; i++) rd(ad[i], i == 5 ? 16'h0001 : 16'h0000);
        pulse(22'h000080);
        irq_is(1'b1);
        wr(16'h752f, 16'h0001);
        irq_is(1'b0);
        for (int i = 0; i < 7; i++) wr(ad[i], 16'hffff);
        for (int i = 0; i < 7; i++) rd(ad[i], wm[i]);
        chk({12'h000, t2_en}, 16'h000f);
        chk({13'h0000, cap_en}, 16'h0007);
        chk({15'h0000, gate}, 16'h0001);
        wr(16'h752c, 16'h0000);
        pulse(22'h3fff80);
        rd(16'h752f, 16'h078f);
        irq_is(1'b0);
        wr(16'h752f, 16'h0080);
        rd(16'h752f, 16'h070f);
        wr(16'h752f, 16'h0001);
        rd(16'h752f, 16'h070e);
        wr(16'h752c, 16'h0002);
        irq_is(1'b1);
        wr(16'h752f, 16'hffff);
        irq_is(1'b0);
        pulse(22'h00007f);
        irq_is(1'b1);
        rd(16'h7530, 16'h000f);
        rd(16'h7531, 16'h0007);
        wr(16'h7531, 16'h0005);
        rd(16'h7531, 16'h0002);
        wr(16'h7530, 16'hffff);
        wr(16'h7531, 16'hffff);
        irq_is(1'b0);
        wr(16'h742d, 16'h0000);
        wr(16'h742e, 16'h0000);
        chk({15'h0000, gate}, 16'h0000);
        // With the clock enable low, neither a write nor an event may land.
        clk_en <= 1'b0;
        wr(16'h742d, 16'h000f);
        pulse(22'h000080);
        clk_en <= 1'b1;
        chk({12'h000, t2_en}, 16'h0000);
        rd(16'h752f, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
